/* File: core/bus_arb_map.svh */
`ifndef BUS_ARB_MAP_SVH
`define BUS_ARB_MAP_SVH
// Number of shared processor request lines
`define ARB_NUM_LINES      6
// Processor index that means single-processor operation
`define ARB_SOLO_INDEX     3'h0
// Reset value of the rotation pointer (line one has top priority)
`define ARB_ROT_RESET      3'h1
// Reset value of the owned-bus flag
`define ARB_OWN_RESET      1'b0
`endif

/* File: core/bus_arb_pkg.sv */
package bus_arb_pkg;
  // Arbitration state of this processor
  typedef enum logic [1:0] {
    ST_SLAVE,
    ST_MASTER,
    ST_HOST
  } arb_state_t;

  // Drive group for one open-drain or three-state pin
  typedef struct packed {
    logic outVal;
    logic outEn;
  } pin_drive_t;

  // Requests this processor's logic makes
  typedef struct packed {
    logic wantBus;
    logic coreAccess;
    logic bootAccess;
  } local_req_t;
endpackage

/* File: core/arb_winner.sv */
`include "bus_arb_map.svh"
// Picks the winning request line under fixed or rotating priority
module arb_winner #(
  parameter int LINES = `ARB_NUM_LINES
) (
  input  wire logic [LINES-1:0] requests,
  input  wire logic             rotate,
  input  wire logic [2:0]       rotStart,
  output logic      [2:0]       winner
);
  // Scan downward in index, ending at the start line; last hit wins, so lowest line wins in fixed mode
  always_comb begin
    int idx;
    logic [2:0] start;
    idx    = 0;
    winner = 3'h0;
    start  = rotate ? rotStart : 3'h1;
    for (int k = LINES - 1; k >= 0; k--) begin
      idx = (int'(start) - 1 + k) % LINES;
      if (requests[idx]) begin
        winner = 3'(idx + 1);
      end
    end
  end
endmodule // arb_winner

/* File: core/multiproc_bus_arbitration.sv */
`include "bus_arb_map.svh"
module multiproc_bus_arbitration #(
  parameter int LINES = `ARB_NUM_LINES
) (
  input  wire logic             clk_sys,             // Processor clock
  input  wire logic             rstn,                // Asynchronous reset, active low
  input  wire logic [2:0]       processorIndex,      // Hardwired processor index
  input  wire logic             rotatePrioritySelect,// High rotating, low fixed
  input  wire bus_arb_pkg::local_req_t localReq,     // Core/DMA requests of this processor
  input  wire logic [LINES-1:0] busRequestLines_n,   // Shared request lines as seen on the pins
  output logic      [LINES-1:0] busRequestOut_n,     // Request line drive values
  output logic      [LINES-1:0] busRequestOe,        // Request line enables, own line only
  input  wire logic             corePriorityIn_n,    // Shared core-priority wire level
  output logic                  corePriorityOut_n,   // Always low when enabled
  output logic                  corePriorityOe,      // High while pulling the wire low
  input  wire logic             suspendBusHiz_n,     // External suspend request, active low
  input  wire logic             hostBusRequest_n,    // Host asks for the bus, active low
  output logic                  hostBusGrant_n,      // Grant to the host, active low
  output logic                  hostBusGrantOe,      // Grant driven only in the host state
  output logic                  bootMemorySelect_n,  // Boot memory chip select, active low
  output logic                  bootMemorySelectOe,  // Boot select driven only by owner
  output logic                  busOutputsOe,        // Enable for address/data/strobes
  output logic                  busOwner,            // This processor owns the bus
  output logic                  dmaPreempt           // Tell local DMA to yield to the core
);
  // Sampled copies of the shared wires; all peers see the same cycle
  logic [LINES-1:0] reqSeen;     // Active-high requests, registered
  logic             cpaSeen;     // Core-priority seen asserted
  logic             hostSeen;    // Host request seen
  logic             suspendSeen; // Suspend request seen
  logic [2:0]       myIndex;     // Index captured after reset release
  logic             indexValid;  // Capture done
  logic [2:0]       rotStart;    // Top-priority line in rotating mode
  logic [2:0]       winner;      // Combinational arbitration result
  logic [LINES-1:0] ownMask;     // One-hot of this processor's line
  logic [2:0]       lastWinner;  // Winner seen one cycle ago
  logic [LINES-1:0] lastMask;    // One-hot of that winner's line
  logic             yieldToCore; // A slave core claims the bus over our DMA
  bus_arb_pkg::arb_state_t state;
  bus_arb_pkg::arb_state_t next_state;

  // Input sampling; pins treated as synchronous so one stage suffices
  // No metastability guard: a truly asynchronous source would need two flops here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reqSeen     <= '0;
      cpaSeen     <= 1'b0;
      hostSeen    <= 1'b0;
      suspendSeen <= 1'b0;
    end else begin
      reqSeen     <= ~busRequestLines_n;
      cpaSeen     <= ~corePriorityIn_n;
      hostSeen    <= ~hostBusRequest_n;
      suspendSeen <= ~suspendBusHiz_n;
    end
  end

  // Index is a strap: caught once after reset release, never again
  // Moving the straps outside reset is not supported; the capture simply ignores it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      myIndex    <= `ARB_SOLO_INDEX;
      indexValid <= 1'b0;
    end else if (!indexValid) begin
      myIndex    <= processorIndex;
      indexValid <= 1'b1;
    end
  end

  // Per-line one-hot masks: own line, and the line that won last cycle
  // Own mask stays empty for a solo or out-of-range index, so such a part never requests
  generate
    for (genvar g = 0; g < LINES; g++) begin : g_own
      assign ownMask[g]  = indexValid && (myIndex == 3'(g + 1));
      assign lastMask[g] = lastWinner == 3'(g + 1);
    end
  endgenerate

  // Core-priority preemption: another line asks while the shared wire is low and
  // our own use is DMA only. The same term bars a regrab, so a master that gave way
  // does not win the bus back in the next cycle while the slave core waits.
  assign yieldToCore = myIndex != `ARB_SOLO_INDEX && (reqSeen & ~ownMask) != '0
                       && cpaSeen && !localReq.coreAccess;

  // Winner search shared by both priority modes; the mode input is read live, so all
  // peers switch in the same clock when the system changes it
  arb_winner #(
    .LINES(LINES)
  ) arb_winner_i (
    .requests(reqSeen),
    .rotate  (rotatePrioritySelect),
    .rotStart(rotStart),
    .winner  (winner)
  );

  // Ownership state machine
  // Slave until own line wins, master until released, host while the host holds it
  always_comb begin
    next_state = state;
    case (state)
      bus_arb_pkg::ST_SLAVE: begin
        if (!indexValid) begin
          next_state = bus_arb_pkg::ST_SLAVE;
        end else if (myIndex == `ARB_SOLO_INDEX) begin
          // Solo processor owns the bus unless the host has it
          next_state = hostSeen ? bus_arb_pkg::ST_SLAVE : bus_arb_pkg::ST_MASTER;
        end else if (!hostSeen && (winner == myIndex) && (reqSeen & ownMask) != '0
                     && !yieldToCore) begin
          // Own line must already be seen on the wire, as the peers see it
          next_state = bus_arb_pkg::ST_MASTER;
        end
      end
      bus_arb_pkg::ST_MASTER: begin
        if (hostSeen) begin
          next_state = bus_arb_pkg::ST_HOST;
        end else if (myIndex != `ARB_SOLO_INDEX && !localReq.wantBus) begin
          next_state = bus_arb_pkg::ST_SLAVE;
        end else if (yieldToCore) begin
          // A slave core needs the bus: DMA-only master yields
          next_state = bus_arb_pkg::ST_SLAVE;
        end
      end
      bus_arb_pkg::ST_HOST: begin
        // Grant held until the host lets go
        if (!hostSeen) begin
          next_state = bus_arb_pkg::ST_SLAVE;
        end
      end
      default: next_state = bus_arb_pkg::ST_SLAVE;
    endcase
  end

  // State register
  // Decisions use registered copies of the shared wires, so every peer steps in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= bus_arb_pkg::ST_SLAVE;
    end else begin
      state <= next_state;
    end
  end

  // Winner of the previous cycle, to spot the moment its line drops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lastWinner <= 3'h0;
    end else begin
      lastWinner <= winner;
    end
  end

  // Rotation: once the winning line lets go, the line after it gets top priority
  // Rotating on every win instead would flip the winner each cycle while two lines wait
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rotStart <= `ARB_ROT_RESET;
    end else if (lastWinner != 3'h0 && (reqSeen & lastMask) == '0) begin
      rotStart <= (lastWinner == 3'(LINES)) ? 3'h1 : lastWinner + 3'h1;
    end
  end

  // Request line drive; only own line enabled, driven low to ask and high when idle
  // A part with no line (solo or index out of range) enables nothing here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busRequestOut_n <= '1;
      busRequestOe    <= '0;
    end else begin
      busRequestOe    <= ownMask;
      busRequestOut_n <= ~(ownMask & {LINES{localReq.wantBus | localReq.coreAccess}});
    end
  end

  // Core-priority: only pull low, never drive high, so peers share the wire
  // The wire has its own pull-up, so an idle part simply lets go of it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      corePriorityOut_n <= 1'b0;
      corePriorityOe    <= 1'b0;
      dmaPreempt        <= 1'b0;
    end else begin
      corePriorityOut_n <= 1'b0;
      corePriorityOe    <= localReq.coreAccess && next_state != bus_arb_pkg::ST_MASTER;
      dmaPreempt        <= next_state == bus_arb_pkg::ST_MASTER && cpaSeen
                           && !localReq.coreAccess;
    end
  end

  // Bus-side enables and host grant; bus outputs and boot select float while suspended
  // Suspend takes effect one cycle after it is sampled, like any other pin input
  // Boot select follows ownership: a slave must never fight the master for it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busOwner           <= `ARB_OWN_RESET;
      busOutputsOe       <= 1'b0;
      hostBusGrant_n     <= 1'b1;
      hostBusGrantOe     <= 1'b0;
      bootMemorySelect_n <= 1'b1;
      bootMemorySelectOe <= 1'b0;
    end else begin
      busOwner           <= next_state == bus_arb_pkg::ST_MASTER;
      busOutputsOe       <= next_state == bus_arb_pkg::ST_MASTER && !suspendSeen;
      // Grant pin is driven by the processor that held the bus
      hostBusGrantOe     <= next_state == bus_arb_pkg::ST_HOST;
      hostBusGrant_n     <= next_state != bus_arb_pkg::ST_HOST;
      bootMemorySelectOe <= next_state == bus_arb_pkg::ST_MASTER && !suspendSeen;
      bootMemorySelect_n <= !(localReq.bootAccess && next_state == bus_arb_pkg::ST_MASTER);
    end
  end
endmodule // multiproc_bus_arbitration

/* File: verification/arb_peer_model.sv */
// Other processors on the shared bus: pulled-up request and core-priority wires
module arb_peer_model (
  input  wire logic [5:0] peerReq_n, // Peer requests, low asks
  input  wire logic       peerCpa_n, // Peer slave core pulls low
  input  wire logic [5:0] reqOut_n,  // Block drive values
  input  wire logic [5:0] reqOe,     // Block enables
  input  wire logic       cpaOut_n,
  input  wire logic       cpaOe,
  output logic      [5:0] lines_n,   // Wired request lines
  output logic            cpa_n      // Wired core-priority line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven lines float to the pull-up, so unused requests read idle
  assign lines_n = peerReq_n & (~reqOe | reqOut_n);
  // Any party pulling low asserts it for all; idle with no puller
  assign cpa_n = peerCpa_n & ~(cpaOe & ~cpaOut_n);
endmodule // arb_peer_model

/* File: verification/multiproc_bus_arbitration_chk.sv */
module multiproc_bus_arbitration_chk #(
  parameter int LINES = 6
) (
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic [2:0]       processorIndex,
  input wire logic [LINES-1:0] busRequestOe,
  input wire logic             corePriorityOut_n,
  input wire logic             corePriorityOe,
  input wire logic             suspendBusHiz_n,
  input wire logic             hostBusRequest_n,
  input wire logic             hostBusGrant_n,
  input wire logic             hostBusGrantOe,
  input wire logic             bootMemorySelectOe,
  input wire logic             busOutputsOe,
  input wire logic             busOwner,
  input wire logic             dmaPreempt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [LINES-1:0] expOe; // Own line only, none outside 1..LINES
  assign expOe = (processorIndex inside {[1:LINES]}) ? LINES'(1) << (processorIndex - 3'h1) : '0;
  chk_own_line: assert property ($past(rstn, 3) |-> busRequestOe == expOe)
    else $error("request enable not the own line");
  chk_cpa_low: assert property (corePriorityOut_n == 1'b0)
    else $error("core-priority drive not low");
  chk_cpa_slave: assert property (corePriorityOe |-> !busOwner)
    else $error("core-priority pulled by owner");
  chk_boot_owner: assert property (bootMemorySelectOe |-> busOwner)
    else $error("boot select driven by non-owner");
  chk_hiz_slave: assert property (busOutputsOe |-> busOwner && !hostBusGrantOe)
    else $error("bus driven while slave");
  chk_hiz_suspend: assert property (
    !suspendBusHiz_n && $past(!suspendBusHiz_n) && $past(!suspendBusHiz_n, 2) |-> !busOutputsOe)
    else $error("bus driven while suspended");
  chk_host_grant: assert property (hostBusGrantOe |-> !hostBusGrant_n && !busOwner)
    else $error("host grant with bus kept");
  chk_host_wins: assert property ($past(!hostBusRequest_n, 2) && $past(!hostBusRequest_n, 3) |-> !busOwner)
    else $error("owner kept bus under host request");
  cover property ($rose(busOwner));
  cover property ($rose(hostBusGrantOe));
  cover property ($rose(dmaPreempt));
endmodule // multiproc_bus_arbitration_chk
bind multiproc_bus_arbitration multiproc_bus_arbitration_chk #(.LINES(LINES)) chk_i (.*);

/* File: verification/multiproc_bus_arbitration_tb.sv */
module multiproc_bus_arbitration_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk_sys = 1'b0; // 20 MHz
  logic                    rstn = 1'b0;
  logic [2:0]              processorIndex = 3'h0;
  logic                    rotatePrioritySelect = 1'b0;
  bus_arb_pkg::local_req_t localReq = '0;
  logic [5:0]              peerReq_n = 6'h3f; // Peers idle
  logic                    peerCpa_n = 1'b1;
  logic                    suspendBusHiz_n = 1'b1;
  logic                    hostBusRequest_n = 1'b1;
  logic [5:0]              busRequestLines_n, busRequestOut_n, busRequestOe;
  logic                    corePriorityIn_n, corePriorityOut_n, corePriorityOe, hostBusGrant_n, hostBusGrantOe;
  logic                    bootMemorySelect_n, bootMemorySelectOe, busOutputsOe, busOwner, dmaPreempt;
  int                      errors = 0;
  int                      comparisons = 0;
  int                      cycles = 0;
  always #25 clk_sys = ~clk_sys;
  multiproc_bus_arbitration multiproc_bus_arbitration_i (.*);
  arb_peer_model arb_peer_model_i (.peerReq_n(peerReq_n), .peerCpa_n(peerCpa_n), .reqOut_n(busRequestOut_n),
    .reqOe(busRequestOe), .cpaOut_n(corePriorityOut_n), .cpaOe(corePriorityOe),
    .lines_n(busRequestLines_n), .cpa_n(corePriorityIn_n));
  task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // The index may only move while reset is held
  task automatic restart(input logic [2:0] idx);
    rstn = 1'b0;
    processorIndex = idx;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic t_index;
    for (int i = 0; i < 8; i++) begin
      restart(3'(i));
      localReq.wantBus = 1'b1;
      repeat (4) @(negedge clk_sys);
      cmp(busRequestOe, (i inside {[1:6]}) ? 6'h01 << (i - 1) : 6'h00);
      cmp(busRequestOe & ~busRequestOut_n, busRequestOe);
      cmp(6'(busOwner), 6'(i < 7));
      localReq.wantBus = 1'b0;
    end
    $display("index test done");
  endtask
  // Line one wins once, then meets line two in the same sample
  task automatic t_prio(input logic m);
    restart(3'h1);
    rotatePrioritySelect = m;
    localReq.wantBus = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmp(6'(busOwner), 6'h01);
    localReq.wantBus = 1'b0;
    repeat (4) @(negedge clk_sys);
    localReq.wantBus = 1'b1;
    @(negedge clk_sys);
    peerReq_n[1] = 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp(6'(busOwner), 6'(!m));
    localReq.wantBus = 1'b0;
    peerReq_n = 6'h3f;
    $display("priority test done");
  endtask
  task automatic t_bus;
    restart(3'h3);
    localReq = 3'b101; // DMA use with boot access
    repeat (4) @(negedge clk_sys);
    cmp({busOwner, busOutputsOe, bootMemorySelectOe, bootMemorySelect_n}, 6'h0e);
    suspendBusHiz_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp({busOwner, busOutputsOe, bootMemorySelectOe}, 6'h04);
    suspendBusHiz_n = 1'b1;
    hostBusRequest_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp({busOwner, busOutputsOe, hostBusGrantOe, hostBusGrant_n}, 6'h02);
    hostBusRequest_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmp({hostBusGrantOe, hostBusGrant_n}, 6'h01);
    localReq = '0;
    $display("bus test done");
  endtask
  task automatic t_core;
    restart(3'h2);
    peerReq_n[0] = 1'b0; // Line one holds the bus
    repeat (3) @(negedge clk_sys);
    localReq.coreAccess = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmp({busOwner, corePriorityOe, corePriorityIn_n}, 6'h02);
    localReq = 3'b100;
    peerReq_n = 6'h3f;
    repeat (5) @(negedge clk_sys);
    // A peer core pulls the shared wire before its request line is seen
    peerCpa_n = 1'b0;
    for (int i = 0; i < 6 && dmaPreempt !== 1'b1; i++) @(negedge clk_sys);
    cmp(6'(dmaPreempt), 6'h01);
    // That slave core now asks for the bus: the DMA-only master must give way
    peerReq_n[0] = 1'b0;
    for (int i = 0; i < 6 && busOwner !== 1'b0; i++) @(negedge clk_sys);
    cmp(6'(busOwner), 6'h00);
    repeat (3) @(negedge clk_sys);
    cmp(6'(busOwner), 6'h00);
    peerCpa_n = 1'b1;
    peerReq_n = 6'h3f;
    localReq = '0;
    $display("core test done");
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    @(negedge clk_sys);
    t_index();
    t_prio(1'b0);
    t_prio(1'b1);
    t_bus();
    t_core();
    conclude();
  end
endmodule // multiproc_bus_arbitration_tb
